// file: logic/occ_pkg.sv
package occ_pkg;

    // ------------------------------------------------------------
    // Register word indices; byte addresses are index times 4
    // ------------------------------------------------------------
    localparam int unsigned IDX_CTRL0 = 32'h0000_00E0;
    localparam int unsigned IDX_CTRL1 = 32'h0000_00E1;
    localparam int unsigned IDX_MTRIM = 32'h0000_00E8;
    localparam int unsigned IDX_LTRIM = 32'h0000_00E9;
    localparam int unsigned IDX_ISTAT = 32'h0000_00F0;
    localparam int unsigned IDX_IMASK = 32'h0000_00F1;
    localparam logic [11:0] ADDR_CTRL0 = 12'(IDX_CTRL0 * 4);
    localparam logic [11:0] ADDR_CTRL1 = 12'(IDX_CTRL1 * 4);
    localparam logic [11:0] ADDR_MTRIM = 12'(IDX_MTRIM * 4);
    localparam logic [11:0] ADDR_LTRIM = 12'(IDX_LTRIM * 4);
    localparam logic [11:0] ADDR_ISTAT = 12'(IDX_ISTAT * 4);
    localparam logic [11:0] ADDR_IMASK = 12'(IDX_IMASK * 4);

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SRC_SEL_BIT = 7;
    localparam int LOCK_EN_BIT = 6;
    localparam int SLEEP_HI    = 4;
    localparam int SLEEP_LO    = 3;
    localparam int CPU_HI      = 2;
    localparam int CPU_LO      = 0;
    localparam int DIV1_HI     = 7;
    localparam int DIV1_LO     = 4;
    localparam int DIV2_HI     = 3;
    localparam int DIV2_LO     = 0;
    localparam int EV_WAKE     = 0;
    localparam int EV_LOCK     = 1;
    localparam int EV_NUM      = 2;

    // ------------------------------------------------------------
    // Reset values and CTRL0 write mask
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL0_WMASK = 8'hDF;

    // ------------------------------------------------------------
    // Timing: slow clock tick divides per sleep code
    // ------------------------------------------------------------
    localparam logic [11:0] WAKE_DIV_512 = 12'h040;
    localparam logic [11:0] WAKE_DIV_64  = 12'h200;
    localparam logic [11:0] WAKE_DIV_8   = 12'hFFF;
    localparam int unsigned LOCK_SETTLE_SLOW = 16;

    typedef enum logic [1:0] {
        SLP_512 = 2'h0,
        SLP_64  = 2'h1,
        SLP_8   = 2'h2
    } occ_sleep_t;

endpackage : occ_pkg

// file: logic/occ_div_if.sv
`timescale 1ns/1ps
interface occ_div_if;
    logic       src_tick;
    logic [3:0] ratio_m1;
    logic       div_tick;
    modport ctl (output src_tick, output ratio_m1, input div_tick);
    modport div (input src_tick, input ratio_m1, output div_tick);
endinterface : occ_div_if

// file: logic/occ_divider.sv
`timescale 1ns/1ps
// Divide a tick stream by ratio_m1+1; ratio only sampled at wrap
module occ_divider (
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    occ_div_if.div    dv
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [3:0] lim_q;
    logic [3:0] lim_d;
    logic       tick_q;
    logic       tick_d;

    always_comb
    begin
        cnt_d  = cnt_q;
        lim_d  = lim_q;
        tick_d = 1'b0;
        if (dv.src_tick)
        begin
            if (cnt_q >= lim_q)
            begin
                // New ratio only at the boundary, no runt pulse
                cnt_d  = 4'h0;
                lim_d  = dv.ratio_m1;
                tick_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q  <= 4'h0;
            lim_q  <= 4'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            lim_q  <= lim_d;
            tick_q <= tick_d;
        end
    end

    assign dv.div_tick = tick_q;

    a_div_boundary: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        tick_q |-> cnt_q == 4'h0)
        else $error("divider tick away from boundary");
endmodule : occ_divider

// file: logic/occ_clock_ctrl.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
// How it works
// - Nominal 32 kHz low-speed source provided
// - One select bit picks crystal or oscillator
// - Oscillator tick offered to digital blocks, whatever the select bit
// - Factory low-speed trim loaded at reset
// - Oscillator in low-current mode during sleep
// - Upper nibble sets first divider, n-1
// - Lower nibble sets second divider, n-1
// - Main oscillator gives 48 and 24 MHz
// - Lock enable locks main oscillator to crystal
// - Main trim loads 5 V factory value
module occ_clock_ctrl #(
    parameter logic [7:0] MTRIM_FACTORY = 8'h80,
    parameter logic [7:0] LTRIM_FACTORY = 8'h80
) (
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        lso_tick_i,
    input  wire logic        xtal_tick_i,
    input  wire logic        xtal_stable_i,
    input  wire logic        main_tick_i,
    input  wire logic        sleep_i,
    output logic             slow_tick_o,
    output logic             blocks_slow_tick_o,
    output logic             lso_low_power_o,
    output logic             wake_irq_tick_o,
    output logic             main_lock_en_o,
    output logic      [7:0]  main_osc_trim_o,
    output logic      [7:0]  low_speed_osc_trim_o,
    output logic      [2:0]  cpu_rate_o,
    output logic             sys_div1_tick_o,
    output logic             sys_div2_tick_o,
    output logic             irq_o
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0]  ctrl0_q;
    logic [7:0]  ctrl0_d;
    logic [7:0]  ctrl1_q;
    logic [7:0]  ctrl1_d;
    logic [7:0]  mtrim_q;
    logic [7:0]  mtrim_d;
    logic [7:0]  ltrim_q;
    logic [7:0]  ltrim_d;
    logic [1:0]  stat_q;
    logic [1:0]  stat_d;
    logic [1:0]  mask_q;
    logic [1:0]  mask_d;
    logic        trim_load_q;
    logic        trim_load_d;
    logic [2:0]  cpu_q;
    logic [2:0]  cpu_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        err_q;
    logic        err_d;
    logic        wr_acc;
    logic        rd_acc;
    logic        hit;
    logic [1:0]  events;

    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign rd_acc = psel_i && !penable_i && !pwrite_i;

    always_comb
    begin
        hit = (paddr_i == occ_pkg::ADDR_CTRL0) || (paddr_i == occ_pkg::ADDR_CTRL1)
           || (paddr_i == occ_pkg::ADDR_MTRIM) || (paddr_i == occ_pkg::ADDR_LTRIM)
           || (paddr_i == occ_pkg::ADDR_ISTAT) || (paddr_i == occ_pkg::ADDR_IMASK);
    end

    always_comb
    begin
        ctrl0_d     = ctrl0_q;
        ctrl1_d     = ctrl1_q;
        mtrim_d     = mtrim_q;
        ltrim_d     = ltrim_q;
        mask_d      = mask_q;
        trim_load_d = 1'b0;
        // Set wins over a write-one clear in the same cycle
        stat_d      = stat_q;
        if (trim_load_q)
        begin
            mtrim_d = MTRIM_FACTORY;
            ltrim_d = LTRIM_FACTORY;
        end
        if (wr_acc)
        begin
            unique case (paddr_i)
                occ_pkg::ADDR_CTRL0: ctrl0_d = pwdata_i[7:0] & occ_pkg::CTRL0_WMASK;
                occ_pkg::ADDR_CTRL1: ctrl1_d = pwdata_i[7:0];
                occ_pkg::ADDR_MTRIM: mtrim_d = pwdata_i[7:0];
                occ_pkg::ADDR_LTRIM: ltrim_d = pwdata_i[7:0];
                occ_pkg::ADDR_ISTAT: stat_d  = stat_q & ~pwdata_i[1:0];
                occ_pkg::ADDR_IMASK: mask_d  = pwdata_i[1:0];
                default:             stat_d  = stat_q;
            endcase
        end
        stat_d = stat_d | events;
    end

    // Reads answer in the access phase; main trim is write-only
    always_comb
    begin
        rdata_d = rdata_q;
        err_d   = err_q;
        if (rd_acc)
        begin
            err_d   = !hit;
            rdata_d = 32'h0000_0000;
            if (paddr_i == occ_pkg::ADDR_CTRL0)
            begin
                rdata_d[7:0] = ctrl0_q;
            end
            if (paddr_i == occ_pkg::ADDR_CTRL1)
            begin
                rdata_d[7:0] = ctrl1_q;
            end
            if (paddr_i == occ_pkg::ADDR_LTRIM)
            begin
                rdata_d[7:0] = ltrim_q;
            end
            if (paddr_i == occ_pkg::ADDR_ISTAT)
            begin
                rdata_d[1:0] = stat_q;
            end
            if (paddr_i == occ_pkg::ADDR_IMASK)
            begin
                rdata_d[1:0] = mask_q;
            end
        end
        else if (psel_i && !penable_i)
        begin
            err_d   = !hit;
            rdata_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl0_q     <= occ_pkg::CTRL0_RST;
            ctrl1_q     <= occ_pkg::CTRL1_RST;
            mtrim_q     <= 8'h00;
            ltrim_q     <= 8'h00;
            stat_q      <= 2'h0;
            mask_q      <= 2'h0;
            trim_load_q <= 1'b1;
            rdata_q     <= 32'h0000_0000;
            err_q       <= 1'b0;
        end
        else
        begin
            ctrl0_q     <= ctrl0_d;
            ctrl1_q     <= ctrl1_d;
            mtrim_q     <= mtrim_d;
            ltrim_q     <= ltrim_d;
            stat_q      <= stat_d;
            mask_q      <= mask_d;
            trim_load_q <= trim_load_d;
            rdata_q     <= rdata_d;
            err_q       <= err_d;
        end
    end

    assign pready_o  = 1'b1;
    assign prdata_o  = rdata_q;
    assign pslverr_o = psel_i && penable_i && err_q;
    assign irq_o     = |(stat_q & mask_q);
    assign main_osc_trim_o      = mtrim_q;
    assign low_speed_osc_trim_o = ltrim_q;

    // ------------------------------------------------------------
    // Slow clock, sleep timer, lock
    // ------------------------------------------------------------
    logic        slow_tick;
    logic [11:0] wake_cnt_q;
    logic [11:0] wake_cnt_d;
    logic [11:0] wake_lim;
    logic        wake_q;
    logic        wake_d;
    logic [4:0]  lock_cnt_q;
    logic [4:0]  lock_cnt_d;
    logic        locked_q;
    logic        locked_d;
    logic        lock_en;

    assign slow_tick = ctrl0_q[occ_pkg::SRC_SEL_BIT] ? xtal_tick_i : lso_tick_i;
    assign lock_en   = ctrl0_q[occ_pkg::LOCK_EN_BIT] && xtal_stable_i;

    always_comb
    begin
        unique case (occ_pkg::occ_sleep_t'(ctrl0_q[occ_pkg::SLEEP_HI:occ_pkg::SLEEP_LO]))
            occ_pkg::SLP_512: wake_lim = occ_pkg::WAKE_DIV_512;
            occ_pkg::SLP_64:  wake_lim = occ_pkg::WAKE_DIV_64;
            default:          wake_lim = occ_pkg::WAKE_DIV_8;
        endcase
    end

    always_comb
    begin
        wake_cnt_d = wake_cnt_q;
        wake_d     = 1'b0;
        lock_cnt_d = lock_cnt_q;
        locked_d   = locked_q;
        if (slow_tick)
        begin
            if (wake_cnt_q >= wake_lim - 12'h001)
            begin
                wake_cnt_d = 12'h000;
                wake_d     = 1'b1;
            end
            else
            begin
                wake_cnt_d = wake_cnt_q + 12'h001;
            end
        end
        if (!lock_en)
        begin
            lock_cnt_d = 5'h00;
            locked_d   = 1'b0;
        end
        else if (slow_tick && !locked_q)
        begin
            lock_cnt_d = lock_cnt_q + 5'h01;
            locked_d   = lock_cnt_q == 5'(occ_pkg::LOCK_SETTLE_SLOW - 1);
        end
        events = 2'h0;
        events[occ_pkg::EV_WAKE] = wake_q;
        events[occ_pkg::EV_LOCK] = locked_d && !locked_q;
    end

    // CPU rate follows the field only on a main clock tick
    always_comb
    begin
        cpu_d = main_tick_i ? ctrl0_q[occ_pkg::CPU_HI:occ_pkg::CPU_LO] : cpu_q;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wake_cnt_q <= 12'h000;
            wake_q     <= 1'b0;
            lock_cnt_q <= 5'h00;
            locked_q   <= 1'b0;
            cpu_q      <= 3'h0;
        end
        else
        begin
            wake_cnt_q <= wake_cnt_d;
            wake_q     <= wake_d;
            lock_cnt_q <= lock_cnt_d;
            locked_q   <= locked_d;
            cpu_q      <= cpu_d;
        end
    end

    assign slow_tick_o        = slow_tick;
    assign blocks_slow_tick_o = lso_tick_i;
    assign lso_low_power_o    = sleep_i;
    assign wake_irq_tick_o    = wake_q;
    assign main_lock_en_o     = lock_en;
    assign cpu_rate_o         = cpu_q;

    // ------------------------------------------------------------
    // System dividers off the 24 MHz main tick
    // ------------------------------------------------------------
    occ_div_if div1_if ();
    occ_div_if div2_if ();

    assign div1_if.src_tick = main_tick_i;
    assign div1_if.ratio_m1 = ctrl1_q[occ_pkg::DIV1_HI:occ_pkg::DIV1_LO];
    assign div2_if.src_tick = main_tick_i;
    assign div2_if.ratio_m1 = ctrl1_q[occ_pkg::DIV2_HI:occ_pkg::DIV2_LO];

    occ_divider u_div1 (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .dv      (div1_if.div)
    );

    occ_divider u_div2 (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .dv      (div2_if.div)
    );

    assign sys_div1_tick_o = div1_if.div_tick;
    assign sys_div2_tick_o = div2_if.div_tick;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_ctrl0_wr;
        wr_acc && paddr_i == occ_pkg::ADDR_CTRL0;
    endsequence

    a_src_select: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        slow_tick_o == (ctrl0_q[7] ? xtal_tick_i : lso_tick_i))
        else $error("slow source mux wrong");
    a_trim_reset: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $fell(trim_load_q) && !$past(wr_acc) |-> mtrim_q == MTRIM_FACTORY && ltrim_q == LTRIM_FACTORY)
        else $error("factory trim not loaded");
    a_sleep_mode: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        lso_low_power_o == sleep_i)
        else $error("low power mode not following sleep");
    a_cpu_field: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_ctrl0_wr ##1 main_tick_i[*2] |=> cpu_rate_o == $past(ctrl0_q[2:0]))
        else $error("cpu rate not applied");
    a_lock_gate: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !xtal_stable_i |-> !main_lock_en_o)
        else $error("lock enabled before crystal stable");
    a_irq_level: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        wake_q && mask_q[0] |=> irq_o)
        else $error("wake interrupt missing");
    a_div1_field: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        div1_if.ratio_m1 == ctrl1_q[7:4] && div2_if.ratio_m1 == ctrl1_q[3:0])
        else $error("divider ratio fields wrong");
    a_cpu_boundary: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !$past(main_tick_i) |-> $stable(cpu_rate_o))
        else $error("cpu rate changed off boundary");
endmodule : occ_clock_ctrl

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [7:0] MT = 8'h80;
    localparam logic [7:0] LT = 8'h80;
    typedef struct {logic [31:0] d; logic e;} occ_note_t;
    logic        clock_i;
    logic        rst_b_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i;
    logic        lso_tick_i;
    logic        xtal_tick_i;
    logic        xtal_stable_i;
    logic        main_tick_i;
    logic        sleep_i;
    logic        lso_run;
    logic        main_rnd;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic        slow_tick_o;
    logic        blocks_slow_tick_o;
    logic        lso_low_power_o;
    logic        wake_irq_tick_o;
    logic        main_lock_en_o;
    logic [7:0]  main_osc_trim_o;
    logic [7:0]  low_speed_osc_trim_o;
    logic [2:0]  cpu_rate_o;
    logic        sys_div1_tick_o;
    logic        sys_div2_tick_o;
    logic        irq_o;
    int          miscompares = 0;
    int          num_checks = 0;
    occ_note_t   note_q[$];

    occ_clock_ctrl #(.MTRIM_FACTORY(MT), .LTRIM_FACTORY(LT)) u_dut (.*);

    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    // Slow source pulses every other cycle; crystal pulses are random
    // Main tick random only while no divider gap is measured
    always @(posedge clock_i)
    begin
        lso_tick_i  <= lso_run & ~lso_tick_i;
        xtal_tick_i <= 1'($urandom);
        main_tick_i <= main_rnd ? 1'($urandom) : 1'b1;
    end

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    always @(posedge clock_i)
    begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
        begin
            if (note_q.size() == 0)
                chk("read note", 32'h0, 32'hFFFF_FFFF);
            else
            begin
                chk("prdata", note_q[0].d, prdata_o);
                chk("pslverr", 32'(note_q[0].e), 32'(pslverr_o));
                void'(note_q.pop_front());
            end
        end
    end

    initial
    begin
        #(60000 * 50);
        miscompares++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Bus and measurement tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        @(posedge clock_i);
        // Only the watchdog ends a wait for the answer
        while (pready_o !== 1'b1)
        begin
            @(posedge clock_i);
        end
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
        note_q.push_back('{e, err});
        apb(1'b0, a, 32'h0);
    endtask : rd

    function automatic logic pick(input int w);
        case (w)
            0: return sys_div1_tick_o;
            1: return sys_div2_tick_o;
            default: return wake_irq_tick_o;
        endcase
    endfunction : pick

    // Cycles between two pulses; first edge found is only a reference
    task automatic gap(input int w, output int g);
        int c;
        c = 0;
        do @(negedge clock_i);
        while (pick(w) !== 1'b1 && ++c < 20000);
        g = 0;
        do
        begin
            @(negedge clock_i);
            g++;
        end
        while (pick(w) !== 1'b1 && g < 20000);
    endtask : gap

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] v;
        logic [7:0] tbl[4];
        int unsigned wd[3];
        int g;
        void'($urandom(71));
        {rst_b_i, psel_i, penable_i, pwrite_i, sleep_i, xtal_stable_i, lso_run, main_rnd} = '0;
        paddr_i = '0;
        pwdata_i = '0;
        lso_tick_i = 1'b0;
        xtal_tick_i = 1'b0;
        main_tick_i = 1'b1;
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rd(occ_pkg::ADDR_CTRL0, 32'h0, 1'b0);
        rd(occ_pkg::ADDR_CTRL1, 32'h0, 1'b0);
        rd(occ_pkg::ADDR_LTRIM, 32'(LT), 1'b0);
        rd(occ_pkg::ADDR_MTRIM, 32'h0, 1'b0);
        chk("main trim", 32'(MT), 32'(main_osc_trim_o));
        rd(12'hFFC, 32'h0, 1'b1);
        v = 8'($urandom);
        apb(1'b1, occ_pkg::ADDR_LTRIM, 32'(v));
        rd(occ_pkg::ADDR_LTRIM, 32'(v), 1'b0);
        chk("low trim", 32'(v), 32'(low_speed_osc_trim_o));
        apb(1'b1, occ_pkg::ADDR_LTRIM, 32'(LT));
        rd(occ_pkg::ADDR_LTRIM, 32'(LT), 1'b0);
        v = 8'($urandom);
        apb(1'b1, occ_pkg::ADDR_MTRIM, 32'(v));
        @(negedge clock_i);
        chk("main trim", 32'(v), 32'(main_osc_trim_o));
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($urandom);
            apb(1'b1, occ_pkg::ADDR_CTRL0, 32'(v));
            rd(occ_pkg::ADDR_CTRL0, 32'(v & occ_pkg::CTRL0_WMASK), 1'b0);
            @(negedge clock_i);
            chk("cpu rate", 32'(v[2:0]), 32'(cpu_rate_o));
        end
        lso_run <= 1'b1;
        main_rnd <= 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            apb(1'b1, occ_pkg::ADDR_CTRL0, 32'(s << 7));
            repeat (8)
            begin
                @(negedge clock_i);
                chk("slow tick", 32'(s ? xtal_tick_i : lso_tick_i), 32'(slow_tick_o));
                chk("blocks tick", 32'(lso_tick_i), 32'(blocks_slow_tick_o));
            end
        end
        for (int s = 1; s >= 0; s--)
        begin
            @(posedge clock_i);
            sleep_i <= 1'(s);
            @(negedge clock_i);
            chk("low power", 32'(s), 32'(lso_low_power_o));
        end
        main_rnd <= 1'b0;
        // Main tick held high, so a ratio of n gives n cycles
        tbl = '{8'h00, 8'h3F, 8'hF2, 8'($urandom)};
        foreach (tbl[i])
        begin
            apb(1'b1, occ_pkg::ADDR_CTRL1, 32'(tbl[i]));
            gap(0, g);
            gap(0, g);
            chk("div1 gap", 32'(tbl[i][7:4]) + 1, 32'(g));
            gap(1, g);
            gap(1, g);
            chk("div2 gap", 32'(tbl[i][3:0]) + 1, 32'(g));
        end
        apb(1'b1, occ_pkg::ADDR_IMASK, 32'h1);
        wd = '{occ_pkg::WAKE_DIV_512, occ_pkg::WAKE_DIV_64, occ_pkg::WAKE_DIV_8};
        for (int c = 0; c < 3; c++)
        begin
            apb(1'b1, occ_pkg::ADDR_CTRL0, 32'(c << 3));
            gap(2, g);
            gap(2, g);
            chk("wake gap", 2 * wd[c], 32'(g));
        end
        @(negedge clock_i);
        chk("irq", 32'h1, 32'(irq_o));
        apb(1'b1, occ_pkg::ADDR_CTRL0, 32'h50);
        @(negedge clock_i);
        chk("lock en", 32'h0, 32'(main_lock_en_o));
        @(posedge clock_i);
        xtal_stable_i <= 1'b1;
        @(negedge clock_i);
        chk("lock en", 32'h1, 32'(main_lock_en_o));
        repeat (2 * occ_pkg::LOCK_SETTLE_SLOW + 20) @(posedge clock_i);
        lso_run <= 1'b0;
        repeat (4) @(posedge clock_i);
        rd(occ_pkg::ADDR_ISTAT, 32'h3, 1'b0);
        apb(1'b1, occ_pkg::ADDR_IMASK, 32'h2);
        @(negedge clock_i);
        chk("irq", 32'h1, 32'(irq_o));
        apb(1'b1, occ_pkg::ADDR_IMASK, 32'h0);
        @(negedge clock_i);
        chk("irq", 32'h0, 32'(irq_o));
        apb(1'b1, occ_pkg::ADDR_ISTAT, 32'h1);
        rd(occ_pkg::ADDR_ISTAT, 32'h2, 1'b0);
        apb(1'b1, occ_pkg::ADDR_IMASK, 32'h1);
        @(negedge clock_i);
        chk("irq", 32'h0, 32'(irq_o));
        apb(1'b1, occ_pkg::ADDR_ISTAT, 32'h2);
        rd(occ_pkg::ADDR_ISTAT, 32'h0, 1'b0);
        rd(occ_pkg::ADDR_IMASK, 32'h1, 1'b0);
        repeat (3) @(posedge clock_i);
        end_sim();
    end
endmodule : tb_top
